// ### core/rq_sideband_capture.sv
/*
 * device end: tracks packet starts on the request stream and captures
 * byte enables, payload offset and start lanes on each first beat.
 * assumes the source keeps its half of the sideband encoding.
 */
`default_nettype none

module rq_sideband_capture #(
    parameter int SIDEBAND_W = rq_sideband_pkg::SIDEBAND_W
) (
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    rq_sideband_if.sink               link,
    input  wire logic                 straddle_en_i,
    input  wire logic                 ready_i,
    output rq_sideband_pkg::tlp_fields_s tlp0_o,
    output rq_sideband_pkg::tlp_fields_s tlp1_o,
    output logic                      tlp0_valid_o,
    output logic                      tlp1_valid_o,
    output logic                      sop_reserved_o
);

    // ************************************************************
    // local constants
    // ************************************************************
    localparam int N_SLOTS = 2;
    localparam int SLOT0   = 0;
    localparam int SLOT1   = 1;

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BODY = 2'b10
    } pkt_e;

    typedef struct packed {
        pkt_e                         st;
        rq_sideband_pkg::tlp_fields_s t0;
        rq_sideband_pkg::tlp_fields_s t1;
        logic                         v0;
        logic                         v1;
        logic                         rsv;
    } state_s;

    state_s                            r;
    state_s                            next_r;
    logic [SIDEBAND_W-1:0]             bus;
    logic [rq_sideband_pkg::SOP_W-1:0] sop;
    logic                              hs;
    logic                              sop_rsv;
    logic [N_SLOTS-1:0]                slot_start;
    rq_sideband_pkg::tlp_fields_s      slot_f [N_SLOTS];

    // ************************************************************
    // decode helpers
    // ************************************************************
    // one byte-enable nibble of a slot
    function automatic logic [3:0] nib(
        input logic [SIDEBAND_W-1:0] b,
        input int                    lo,
        input int                    slot
    );
        nib = b[lo + slot * rq_sideband_pkg::NIBBLE_W +: rq_sideband_pkg::NIBBLE_W];
    endfunction

    // payload offset; reserved bits and second slot read as zero
    function automatic logic [1:0] offset_of(
        input logic [SIDEBAND_W-1:0] b,
        input int                    slot
    );
        if (slot == SLOT0)
            offset_of = b[rq_sideband_pkg::OFFSET_LO +: rq_sideband_pkg::OFFSET_USED_W];
        else
            offset_of = '0;
    endfunction

    // start lane of a slot; lane 0 when not straddling
    function automatic logic [1:0] lane_of(
        input logic [SIDEBAND_W-1:0] b,
        input int                    slot,
        input logic                  straddle
    );
        if (!straddle)
            lane_of = rq_sideband_pkg::LANE_0;
        else if (slot == SLOT0)
            lane_of = b[rq_sideband_pkg::LANE0_LO +: rq_sideband_pkg::LANE_W];
        else
            lane_of = b[rq_sideband_pkg::LANE1_LO +: rq_sideband_pkg::LANE_W];
    endfunction

    // all captured fields of one slot
    function automatic rq_sideband_pkg::tlp_fields_s fields_of(
        input logic [SIDEBAND_W-1:0] b,
        input int                    slot,
        input logic                  straddle
    );
        fields_of.first_dword_byte_enables = nib(b, rq_sideband_pkg::FIRST_DWORD_BYTE_ENABLES_LO, slot);
        fields_of.last_dword_byte_enables  = nib(b, rq_sideband_pkg::LAST_DWORD_BYTE_ENABLES_LO, slot);
        fields_of.offset   = offset_of(b, slot);
        fields_of.lane     = lane_of(b, slot, straddle);
    endfunction

    // which slots start a tlp in this beat
    function automatic logic [N_SLOTS-1:0] starts_of(
        input logic [rq_sideband_pkg::SOP_W-1:0] code,
        input logic                              straddle,
        input logic                              idle
    );
        starts_of = '0;
        if (!straddle)
            starts_of[SLOT0] = idle;
        else
        begin
            unique case (code)
                rq_sideband_pkg::SOP_NONE:     starts_of = '0;
                rq_sideband_pkg::SOP_ONE:      starts_of[SLOT0] = 1'b1;
                rq_sideband_pkg::SOP_TWO:      starts_of = '1;
                rq_sideband_pkg::SOP_RESERVED: starts_of = '0;
            endcase
        end
    endfunction

    // ************************************************************
    // slot decode
    // ************************************************************
    assign bus        = link.request_sideband_bus;
    assign sop        = bus[rq_sideband_pkg::SOP_LO +: rq_sideband_pkg::SOP_W];
    assign hs         = link.request_stream_valid && link.request_stream_ready;
    assign sop_rsv    = straddle_en_i && (sop == rq_sideband_pkg::SOP_RESERVED);
    assign slot_start = starts_of(sop, straddle_en_i, r.st == ST_IDLE);

    generate
        for (genvar s = 0; s < N_SLOTS; s++)
        begin : g_slot
            assign slot_f[s] = fields_of(bus, s, straddle_en_i);
        end
    endgenerate

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_r     = r;
        next_r.v0  = 1'b0;
        next_r.v1  = 1'b0;
        next_r.rsv = hs && sop_rsv;
        if (hs)
        begin
            unique case (r.st)
                ST_IDLE: next_r.st = link.request_stream_last ? ST_IDLE : ST_BODY;
                ST_BODY: next_r.st = link.request_stream_last ? ST_IDLE : ST_BODY;
            endcase
            if (slot_start[SLOT0])
            begin
                next_r.v0 = 1'b1;
                next_r.t0 = slot_f[SLOT0];
            end
            if (slot_start[SLOT1])
            begin
                next_r.v1 = 1'b1;
                next_r.t1 = slot_f[SLOT1];
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            r    <= '0;
            r.st <= ST_IDLE;
        end
        else
            r <= next_r;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign link.request_stream_ready = ready_i;
    assign tlp0_o         = r.t0;
    assign tlp1_o         = r.t1;
    assign tlp0_valid_o   = r.v0;
    assign tlp1_valid_o   = r.v1;
    assign sop_reserved_o = r.rsv;

endmodule // rq_sideband_capture

`default_nettype wire

// ### core/rq_sideband_if.sv
/*
 * carrier between the stream source and the sideband capture end.
 * assumes clk and rstn come from the enclosing bench.
 */
`default_nettype none

interface rq_sideband_if (
    input wire logic clk,
    input wire logic rstn
);
    logic [rq_sideband_pkg::SIDEBAND_W-1:0] request_sideband_bus;
    logic                                   request_stream_valid;
    logic                                   request_stream_ready;
    logic                                   request_stream_last;

    modport source (
        output request_sideband_bus,
        output request_stream_valid,
        output request_stream_last,
        input  request_stream_ready
    );

    modport sink (
        input  request_sideband_bus,
        input  request_stream_valid,
        input  request_stream_last,
        output request_stream_ready
    );
endinterface

`default_nettype wire

// ### core/rq_sideband_pkg.sv
/*
 * constants and types shared by both ends of the request sideband link:
 * sideband field positions, widths, start-flag codes and lane codes.
 * assumes a single 125 MHz clock shared by both ends.
 */
`default_nettype none

package rq_sideband_pkg;

    // ************************************************************
    // sideband layout
    // ************************************************************
    localparam int SIDEBAND_W    = 26;
    localparam int FIRST_DWORD_BYTE_ENABLES_LO   = 0;
    localparam int LAST_DWORD_BYTE_ENABLES_LO    = 8;
    localparam int BE_W          = 8;
    localparam int NIBBLE_W      = 4;
    localparam int OFFSET_LO     = 16;
    localparam int OFFSET_W      = 4;
    localparam int OFFSET_USED_W = 2;
    localparam int SOP_LO        = 20;
    localparam int SOP_W         = 2;
    localparam int LANE0_LO      = 22;
    localparam int LANE1_LO      = 24;
    localparam int LANE_W        = 2;

    // ************************************************************
    // start flag codes
    // ************************************************************
    localparam logic [1:0] SOP_NONE     = 2'h0;
    localparam logic [1:0] SOP_ONE      = 2'h1;
    localparam logic [1:0] SOP_RESERVED = 2'h2;
    localparam logic [1:0] SOP_TWO      = 2'h3;

    // ************************************************************
    // lane codes and reset values
    // ************************************************************
    localparam logic [1:0] LANE_0      = 2'h0;
    localparam logic [1:0] LANE_32     = 2'h2;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [3:0] OFFSET_ZERO = 4'h0;

    typedef struct packed {
        logic [3:0] first_dword_byte_enables;
        logic [3:0] last_dword_byte_enables;
        logic [1:0] offset;
        logic [1:0] lane;
    } tlp_fields_s;

endpackage

`default_nettype wire

// ### core/rq_sideband_source.sv
/*
 * user-side end: packs up to two tlp field sets into the sideband bus
 * and presents one beat at a time under valid/ready.
 * assumes the user holds its beat inputs until beat_accept_o pulses.
 */
`default_nettype none

module rq_sideband_source (
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    rq_sideband_if.source             link,
    input  wire logic                 beat_valid_i,
    input  wire logic                 beat_last_i,
    input  wire logic                 beat_sop_i,
    input  wire logic                 beat_second_sop_i,
    input  wire logic                 straddle_en_i,
    input  wire logic                 addr_aligned_i,
    input  wire logic                 single_dword_i,
    input  wire logic                 single_dword1_i,
    input  wire rq_sideband_pkg::tlp_fields_s tlp0_i,
    input  wire rq_sideband_pkg::tlp_fields_s tlp1_i,
    output logic                      beat_accept_o
);

    typedef struct packed {
        logic                                   valid;
        logic                                   last;
        logic [rq_sideband_pkg::SIDEBAND_W-1:0] bus;
    } state_s;

    state_s r;
    state_s next_r;

    function automatic logic [3:0] last_nib(input logic [3:0] be, input logic one_dw);
        last_nib = one_dw ? rq_sideband_pkg::NIBBLE_ZERO : be;
    endfunction

    // ************************************************************
    // beat packing
    // ************************************************************
    always_comb
    begin
        logic two;
        logic [3:0] off;
        two    = beat_sop_i && beat_second_sop_i && straddle_en_i;
        off    = addr_aligned_i ? {2'h0, tlp0_i.offset} : rq_sideband_pkg::OFFSET_ZERO;
        next_r = r;
        if (!r.valid || link.request_stream_ready)
        begin
            next_r.valid = beat_valid_i;
            next_r.last  = beat_last_i;
            next_r.bus   = '0;
            next_r.bus[rq_sideband_pkg::FIRST_DWORD_BYTE_ENABLES_LO +: rq_sideband_pkg::BE_W] =
                {two ? tlp1_i.first_dword_byte_enables : rq_sideband_pkg::NIBBLE_ZERO, tlp0_i.first_dword_byte_enables};
            next_r.bus[rq_sideband_pkg::LAST_DWORD_BYTE_ENABLES_LO +: rq_sideband_pkg::BE_W] =
                {two ? last_nib(tlp1_i.last_dword_byte_enables, single_dword1_i) : rq_sideband_pkg::NIBBLE_ZERO,
                 last_nib(tlp0_i.last_dword_byte_enables, single_dword_i)};
            next_r.bus[rq_sideband_pkg::OFFSET_LO +: rq_sideband_pkg::OFFSET_W] = off;
            next_r.bus[rq_sideband_pkg::SOP_LO +: rq_sideband_pkg::SOP_W] =
                !beat_sop_i ? rq_sideband_pkg::SOP_NONE :
                (two ? rq_sideband_pkg::SOP_TWO : rq_sideband_pkg::SOP_ONE);
            next_r.bus[rq_sideband_pkg::LANE0_LO +: rq_sideband_pkg::LANE_W] = tlp0_i.lane;
            next_r.bus[rq_sideband_pkg::LANE1_LO +: rq_sideband_pkg::LANE_W] =
                two ? tlp1_i.lane : rq_sideband_pkg::LANE_0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            r <= '0;
        else
            r <= next_r;
    end

    assign link.request_sideband_bus = r.bus;
    assign link.request_stream_valid = r.valid;
    assign link.request_stream_last  = r.last;
    assign beat_accept_o             = beat_valid_i && (!r.valid || link.request_stream_ready);

endmodule // rq_sideband_source

`default_nettype wire

// ### verif/rq_sideband_chk.sv
/* checker on the wires between the two ends
   assumes the bench feeds it the carrier signals */
`default_nettype none
module rq_sideband_chk (
    input wire logic                                   clk,
    input wire logic                                   rstn,
    input wire logic [rq_sideband_pkg::SIDEBAND_W-1:0] request_sideband_bus,
    input wire logic                                   request_stream_valid,
    input wire logic                                   request_stream_ready,
    input wire logic                                   request_stream_last
);
    // ****************************************
    // link properties
    // ****************************************
    wire logic [25:0] b = request_sideband_bus;
    wire logic v = request_stream_valid;
    wire logic one = v && !b[21];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_stall; v && !request_stream_ready; endsequence
    property p_valid; s_stall |=> v; endproperty
    a_valid: assert property (p_valid) else $error("valid dropped");
    property p_bus; s_stall |=> $stable(b); endproperty
    a_bus: assert property (p_bus) else $error("bus moved");
    property p_last; s_stall |=> $stable(request_stream_last); endproperty
    a_last: assert property (p_last) else $error("last moved");
    property p_rsv; v |-> b[19:18] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("offset top set");
    property p_code; v |-> b[21:20] != rq_sideband_pkg::SOP_RESERVED; endproperty
    a_code: assert property (p_code) else $error("start code 10");
    property p_fhi; one |-> b[7:4] == 4'h0; endproperty
    a_fhi: assert property (p_fhi) else $error("first upper set");
    property p_lhi; one |-> b[15:12] == 4'h0; endproperty
    a_lhi: assert property (p_lhi) else $error("last upper set");
    property p_lane; one |-> b[25:24] == 2'h0; endproperty
    a_lane: assert property (p_lane) else $error("lane1 set");
endmodule // rq_sideband_chk
`default_nettype wire

// ### verif/tb.sv
/* bench: source end facing capture end over the carrier
   assumes package, carrier and both ends compiled first */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // stimulus and scoreboard
    // ****************************************
    typedef rq_sideband_pkg::tlp_fields_s f_t;
    typedef struct packed { f_t t0; f_t t1; logic two; } note_s;
    logic  clk_i = 0, rstn_i = 0, bv = 0, bl = 0, bs = 0, b2 = 0, st = 0;
    logic  al = 0, s0 = 0, s1 = 0, rdy = 0, acc, v0, v1, rsv;
    f_t    t0 = '0, t1 = '0, o0, o1;
    int    n_fail = 0, total_checks = 0, cyc = 0, seed = 32'h3f3ae5bf;
    logic  start = 1;
    note_s q[$];
    note_s n;
    always #4 clk_i = ~clk_i;
    rq_sideband_if i_rq_sideband_if (.clk(clk_i), .rstn(rstn_i));
    rq_sideband_source i_rq_sideband_source (.clk_i(clk_i), .rstn_i(rstn_i), .link(i_rq_sideband_if),
        .beat_valid_i(bv), .beat_last_i(bl), .beat_sop_i(bs), .beat_second_sop_i(b2),
        .straddle_en_i(st), .addr_aligned_i(al), .single_dword_i(s0), .single_dword1_i(s1),
        .tlp0_i(t0), .tlp1_i(t1), .beat_accept_o(acc));
    rq_sideband_capture i_rq_sideband_capture (.clk_i(clk_i), .rstn_i(rstn_i), .link(i_rq_sideband_if),
        .straddle_en_i(st), .ready_i(rdy), .tlp0_o(o0), .tlp1_o(o1), .tlp0_valid_o(v0),
        .tlp1_valid_o(v1), .sop_reserved_o(rsv));
    rq_sideband_chk u_chk (.clk(clk_i), .rstn(rstn_i),
        .request_sideband_bus(i_rq_sideband_if.request_sideband_bus),
        .request_stream_valid(i_rq_sideband_if.request_stream_valid),
        .request_stream_ready(i_rq_sideband_if.request_stream_ready),
        .request_stream_last(i_rq_sideband_if.request_stream_last));
    task automatic chk_f(input string nm, input f_t e, input f_t g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_b(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic f_t exp_f(input f_t t, input logic single, input logic first);
        exp_f = t;
        if (single)
            exp_f.last_dword_byte_enables = 4'h0;
        if (!first || !al)
            exp_f.offset = 2'h0;
        if (!st)
            exp_f.lane = 2'h0;
    endfunction
    task automatic beat(input logic sop, input logic two, input logic last);
        logic s;
        s = st ? sop : start;
        bv <= 1;
        bs <= s;
        b2 <= s & two;
        bl <= last;
        t0 <= f_t'($random(seed));
        t1 <= f_t'($random(seed));
        s0 <= 1'($random(seed));
        s1 <= 1'($random(seed));
        al <= 1'($random(seed));
        do @(negedge clk_i); while (acc !== 1'b1);
        if (s)
            q.push_back('{exp_f(t0, s0, 1'b1), exp_f(t1, s1, 1'b0), st & two});
        start = last;
        @(posedge clk_i);
    endtask
    always @(posedge clk_i)
    begin
        rdy <= 1'($random(seed));
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            end_sim;
        end
    end
    always @(negedge clk_i)
    begin
        if (rsv !== 1'b0)
            chk_b("reserved", 1'b0, rsv);
        if (v0 === 1'b1 || v1 === 1'b1)
        begin
            chk_b("note", 1'b1, q.size() != 0);
            n = (q.size() != 0) ? q.pop_front() : '0;
            chk_b("valid0", 1'b1, v0);
            chk_f("tlp0", n.t0, o0);
            chk_b("valid1", n.two, v1);
            if (n.two)
                chk_f("tlp1", n.t1, o1);
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1;
        for (int p = 0; p < 2; p++)
        begin
            st <= p[0];
            repeat (2) @(posedge clk_i);
            for (int i = 0; i < 80; i++)
                beat(1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
            beat(1'b1, 1'b1, 1'b1);
            bv <= 0;
            do @(negedge clk_i); while (i_rq_sideband_if.request_stream_valid === 1'b1);
            repeat (4) @(posedge clk_i);
        end
        chk_b("drained", 1'b1, q.size() == 0);
        end_sim;
    end
endmodule // tb
`default_nettype wire
